// ===== timer_readback.v
`timescale 1ns/1ps
`include "timer_readback_defs.vh"
// Read path of a three-counter interval timer: host port, latch and
// read-back commands, status byte and load-pending flags.
// Counting stays in the core; this block only reads and commands it.
module timer_readback #(
    parameter COUNT_WIDTH = 16,
    parameter NUM_COUNTERS = 3
) (
    input wire sys_clk,
    input wire rst_b,
    // Host parallel port
    input wire cs_b,
    input wire rd_b,
    input wire wr_b,
    input wire port_select_high,
    input wire port_select_low,
    input wire [7:0] data_in,
    output reg [7:0] data_out_q,
    output reg data_oe_b_q,
    // Counter core side
    input wire [NUM_COUNTERS*COUNT_WIDTH-1:0] count_element,
    input wire [NUM_COUNTERS-1:0] out_level,
    input wire [NUM_COUNTERS-1:0] count_loaded,
    output reg [NUM_COUNTERS-1:0] mode_load_q,
    output reg [NUM_COUNTERS*6-1:0] mode_field_q,
    output reg [NUM_COUNTERS-1:0] count_register_load_q,
    output reg [NUM_COUNTERS*COUNT_WIDTH-1:0] count_register_q
);

    // ----------------------------------------
    // Host pin synchronisation
    // ----------------------------------------
    wire [12:0] pins_raw;
    wire [12:0] pins_s;

    wire cs_b_s;
    wire rd_b_s;
    wire wr_b_s;
    wire [1:0] addr_s;
    wire [7:0] data_s;

    assign pins_raw = {cs_b, rd_b, wr_b, port_select_high, port_select_low, data_in};

    // Cost: every host access is seen two clocks late
    // Strobes idle high; reset value keeps them inactive
    pin_sync #(
        .WIDTH(13),
        .RESET_VALUE(13'h1C00)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in(pins_raw),
        .pin_sync_q(pins_s)
    );

    assign cs_b_s = pins_s[12];
    assign rd_b_s = pins_s[11];
    assign wr_b_s = pins_s[10];
    assign addr_s = pins_s[9:8];
    assign data_s = pins_s[7:0];

    // ----------------------------------------
    // Bus strobe decode
    // ----------------------------------------
    reg wr_active_q;
    reg [1:0] wr_addr_q;
    reg [7:0] wr_data_q;
    reg rd_active_q;
    reg [1:0] rd_addr_q;

    wire wr_now;
    wire rd_now;
    wire wr_done;
    wire rd_done;

    // A strobe pulse shorter than one clock may be lost
    // Control location reads are a no-operation and float the bus
    assign wr_now = !cs_b_s && !wr_b_s && rd_b_s;
    assign rd_now = !cs_b_s && !rd_b_s && wr_b_s && (addr_s != `PORT_CONTROL);
    // Writes act at the trailing edge, when address and data are settled
    assign wr_done = wr_active_q && !wr_now;
    assign rd_done = rd_active_q && !rd_now;

    // Track strobes and capture address and data while they are low
    // Address kept from the last low cycle, so a late change is harmless
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_active_q <= 1'b0;
            wr_addr_q <= 2'h0;
            wr_data_q <= `RST_BYTE;
            rd_active_q <= 1'b0;
            rd_addr_q <= 2'h0;
        end else begin
            wr_active_q <= wr_now;
            rd_active_q <= rd_now;
            if (wr_now) begin
                wr_addr_q <= addr_s;
                wr_data_q <= data_s;
            end
            if (rd_now) begin
                rd_addr_q <= addr_s;
            end
        end
    end

    // ----------------------------------------
    // Control word decode
    // ----------------------------------------
    wire ctrl_wr;
    wire [1:0] cw_sel;
    wire [1:0] cw_rw;
    wire is_readback;
    wire is_latch;
    wire is_mode;

    reg [NUM_COUNTERS-1:0] sel_onehot;
    reg [NUM_COUNTERS-1:0] rb_sel;
    reg [NUM_COUNTERS-1:0] latch_count_req;
    reg [NUM_COUNTERS-1:0] latch_status_req;
    reg [NUM_COUNTERS-1:0] mode_wr;
    reg [NUM_COUNTERS-1:0] data_wr;
    reg [NUM_COUNTERS-1:0] data_rd_done;

    integer k;

    assign ctrl_wr = wr_done && (wr_addr_q == `PORT_CONTROL);
    assign cw_sel = wr_data_q[`CW_SEL_HI:`CW_SEL_LO];
    assign cw_rw = wr_data_q[`CW_RW_HI:`CW_RW_LO];
    // Read-back needs bit zero clear; with it set the word is ignored
    assign is_readback = ctrl_wr && (cw_sel == `CW_SEL_READBACK) && !wr_data_q[`CW_RB_ZERO];
    // Bits five and four split latch words from mode words
    assign is_latch = ctrl_wr && (cw_sel != `CW_SEL_READBACK) && (cw_rw == `CW_RW_LATCH);
    assign is_mode = ctrl_wr && (cw_sel != `CW_SEL_READBACK) && (cw_rw != `CW_RW_LATCH);

    // Per-counter request strobes, one cycle each
    always @* begin
        sel_onehot = {NUM_COUNTERS{1'b0}};
        rb_sel = {NUM_COUNTERS{1'b0}};
        latch_count_req = {NUM_COUNTERS{1'b0}};
        latch_status_req = {NUM_COUNTERS{1'b0}};
        mode_wr = {NUM_COUNTERS{1'b0}};
        data_wr = {NUM_COUNTERS{1'b0}};
        data_rd_done = {NUM_COUNTERS{1'b0}};
        for (k = 0; k < NUM_COUNTERS; k = k + 1) begin
            sel_onehot[k] = (cw_sel == k[1:0]);
            // An empty selection leaves every request low
            rb_sel[k] = is_readback && wr_data_q[`CW_RB_SEL_LO + k];
            latch_count_req[k] = (is_latch && sel_onehot[k]) ||
                                 (rb_sel[k] && !wr_data_q[`CW_RB_COUNT]);
            latch_status_req[k] = rb_sel[k] && !wr_data_q[`CW_RB_STATUS];
            mode_wr[k] = is_mode && sel_onehot[k];
            data_wr[k] = wr_done && (wr_addr_q == k[1:0]);
            // Control address reads never raise a done strobe
            data_rd_done[k] = rd_done && (rd_addr_q == k[1:0]);
        end
    end

    // ----------------------------------------
    // Per-counter read and write state
    // ----------------------------------------
    wire [NUM_COUNTERS*8-1:0] read_byte;

    genvar g;
    generate
        for (g = 0; g < NUM_COUNTERS; g = g + 1) begin : g_counter
            reg [5:0] mode_q;
            reg null_count_q;
            reg status_held_q;
            reg [7:0] status_q;
            reg rd_msb_q;
            reg wr_msb_q;
            reg [7:0] lsb_hold_q;
            reg [7:0] byte_sel;

            wire [1:0] rw_fmt;
            wire [COUNT_WIDTH-1:0] ol_value;
            wire count_release;
            wire full_count_write;
            wire high_byte_read;

            assign rw_fmt = mode_q[`CW_RW_HI:`CW_RW_LO];
            // Second byte of a pair is high; MSB-only format is always high
            // One-byte formats never move the pointer
            assign high_byte_read = (rw_fmt == `CW_RW_MSB) || ((rw_fmt == `CW_RW_BOTH) && rd_msb_q);
            // Count unlatches after its last byte, and only once status is out
            assign count_release = mode_wr[g] ||
                (data_rd_done[g] && !status_held_q && !((rw_fmt == `CW_RW_BOTH) && !rd_msb_q));

            // Unprogrammed counters ignore writes: no load pulse, no flag
            assign full_count_write = data_wr[g] &&
                (rw_fmt != `CW_RW_LATCH) &&
                !((rw_fmt == `CW_RW_BOTH) && !wr_msb_q);

            // Latch does not touch mode or the core, only the hold register
            // Held flag unused: release and freeze carry the state
            count_hold #(
                .WIDTH(COUNT_WIDTH)
            ) u_count_hold (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .count_element(count_element[g*COUNT_WIDTH +: COUNT_WIDTH]),
                .freeze(latch_count_req[g]),
                .release_hold(count_release),
                .output_latch_q(ol_value),
                .held_q()
            );

            // Byte presented on a read: status first, then count bytes
            always @* begin
                byte_sel = ol_value[7:0];
                if (status_held_q) begin
                    byte_sel = status_q;
                end else if (high_byte_read) begin
                    byte_sel = ol_value[15:8];
                end
            end
            assign read_byte[g*8 +: 8] = byte_sel;

            // Mode field, status latch and read byte pointer
            // Status takes the flag as it stood before this edge
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    mode_q <= `RST_MODE;
                    status_held_q <= 1'b0;
                    status_q <= `RST_BYTE;
                    rd_msb_q <= 1'b0;
                end else if (mode_wr[g]) begin
                    mode_q <= wr_data_q[`CW_MODE_HI:`CW_MODE_LO];
                    status_held_q <= 1'b0;
                    rd_msb_q <= 1'b0;
                end else begin
                    if (latch_status_req[g] && !status_held_q) begin
                        status_held_q <= 1'b1;
                        status_q <= {out_level[g], null_count_q, mode_q};
                    end
                    if (data_rd_done[g]) begin
                        if (status_held_q) begin
                            status_held_q <= 1'b0;
                        end else if (rw_fmt == `CW_RW_BOTH) begin
                            rd_msb_q <= !rd_msb_q;
                        end
                    end
                end
            end

            // Write byte pointer and count register assembly
            // A mode word restarts the pair, like the read side
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    wr_msb_q <= 1'b0;
                    lsb_hold_q <= `RST_BYTE;
                    count_register_load_q[g] <= 1'b0;
                    count_register_q[g*COUNT_WIDTH +: COUNT_WIDTH] <= `RST_WORD;
                end else begin
                    count_register_load_q[g] <= full_count_write;
                    if (mode_wr[g]) begin
                        wr_msb_q <= 1'b0;
                    end else if (data_wr[g]) begin
                        case (rw_fmt)
                            `CW_RW_LSB: begin
                                count_register_q[g*COUNT_WIDTH +: COUNT_WIDTH] <= {8'h00, wr_data_q};
                            end
                            `CW_RW_MSB: begin
                                count_register_q[g*COUNT_WIDTH +: COUNT_WIDTH] <= {wr_data_q, 8'h00};
                            end
                            `CW_RW_BOTH: begin
                                // Independent of the read pointer
                                wr_msb_q <= !wr_msb_q;
                                if (!wr_msb_q) begin
                                    lsb_hold_q <= wr_data_q;
                                end else begin
                                    count_register_q[g*COUNT_WIDTH +: COUNT_WIDTH] <= {wr_data_q, lsb_hold_q};
                                end
                            end
                            default: begin
                                wr_msb_q <= 1'b0;
                            end
                        endcase
                    end
                end
            end

            // Load-pending flag; a new write in the transfer cycle wins
            // Losing that write would report a stale count as loaded
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    null_count_q <= 1'b0;
                end else if (mode_wr[g] || full_count_write) begin
                    null_count_q <= 1'b1;
                end else if (count_loaded[g]) begin
                    null_count_q <= 1'b0;
                end
            end

            // Mode field and strobe towards the counter core
            // Pulse and field move on one edge, never half a word
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    mode_load_q[g] <= 1'b0;
                    mode_field_q[g*6 +: 6] <= `RST_MODE;
                end else begin
                    mode_load_q[g] <= mode_wr[g];
                    if (mode_wr[g]) begin
                        mode_field_q[g*6 +: 6] <= wr_data_q[`CW_MODE_HI:`CW_MODE_LO];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Host data bus drive
    // ----------------------------------------
    reg [7:0] rd_mux;

    integer m;

    // Live reads show the counting element, so an unstopped clock may tear
    // Control address never gets here; it floats the bus
    always @* begin
        rd_mux = 8'h00;
        for (m = 0; m < NUM_COUNTERS; m = m + 1) begin
            if (rd_addr_q == m[1:0]) begin
                rd_mux = read_byte[m*8 +: 8];
            end
        end
    end

    // Drive the bus only while a counter read is in progress
    // Data keeps its last byte when floated, saving a mux
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_out_q <= `RST_BYTE;
            data_oe_b_q <= 1'b1;
        end else begin
            data_oe_b_q <= !rd_active_q;
            if (rd_active_q) begin
                data_out_q <= rd_mux;
            end
        end
    end

endmodule // timer_readback

// ===== timer_readback_defs.vh
// Functional notes
// - Latch command: control location, address 11, bits five and four 00.
// - Latch freezes output latch until count fully read or counter reprogrammed.
// - Latching leaves mode and counting untouched; several counters may hold latches.
// - Second latch command before the count is read is ignored.
// - Two-byte counters read as two bytes in programmed order; other accesses may interleave.
// - Read and write byte progress are tracked separately per counter.
// - Read-back: bits seven and six 1, bit zero 0; bits 3,2,1 select counters.
// - Read-back count bit 0 latches every selected counter; each unlatches on its read.
// - Repeated count read-backs without a count read are ignored after the first.
// - Read-back status bit 0 latches status; status only readable this way.
// - Status bits five to zero hold the last written mode field.
// - Status bit seven holds the output pin level at latch time.
// - Status bit six is load-pending: set on write, cleared on count transfer.
// - Mode write sets load-pending only for the addressed counter.
// - Two-byte counters set load-pending only when the high byte is written.
// - Before transfer, latch or read returns the old counting element value.
// - Repeated status latches without a status read are ignored after the first.
// - Bits five and four both 0 latch count and status, repeats ignored.
// - Status is read first when both latched, then the count bytes, then live.
`ifndef TIMER_READBACK_DEFS_VH
`define TIMER_READBACK_DEFS_VH

// ----------------------------------------
// Port addresses
// ----------------------------------------
`define PORT_COUNTER_0 2'h0
`define PORT_COUNTER_1 2'h1
`define PORT_COUNTER_2 2'h2
`define PORT_CONTROL 2'h3

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define CW_SEL_HI 7
`define CW_SEL_LO 6
`define CW_RW_HI 5
`define CW_RW_LO 4
`define CW_MODE_HI 5
`define CW_MODE_LO 0
`define CW_RB_COUNT 5
`define CW_RB_STATUS 4
`define CW_RB_SEL_HI 3
`define CW_RB_SEL_LO 1
`define CW_RB_ZERO 0
`define CW_SEL_READBACK 2'h3
`define CW_RW_LATCH 2'h0
`define CW_RW_LSB 2'h1
`define CW_RW_MSB 2'h2
`define CW_RW_BOTH 2'h3

// ----------------------------------------
// Status byte fields
// ----------------------------------------
`define ST_OUTPUT 7
`define ST_NULL 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_MODE 6'h00

`endif

// ===== pin_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous pin inputs
module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] pin_sync_q
);

    reg [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RESET_VALUE;
            pin_sync_q <= RESET_VALUE;
        end else begin
            meta_q <= pin_in;
            pin_sync_q <= meta_q;
        end
    end

endmodule // pin_sync

// ===== count_hold.v
`timescale 1ns/1ps
`include "timer_readback_defs.vh"
// Output latch of one counter: follows the counting element until frozen
module count_hold #(
    parameter WIDTH = 16
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [WIDTH-1:0] count_element,
    input wire freeze,
    input wire release_hold,
    output reg [WIDTH-1:0] output_latch_q,
    output reg held_q
);

    // Freeze only when not already held, so the first capture survives
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            output_latch_q <= {WIDTH{1'b0}};
            held_q <= 1'b0;
        end else if (release_hold) begin
            held_q <= 1'b0;
            output_latch_q <= count_element;
        end else if (freeze && !held_q) begin
            held_q <= 1'b1;
            output_latch_q <= count_element;
        end else if (!held_q) begin
            output_latch_q <= count_element;
        end
    end

endmodule // count_hold

// ===== timer_readback_monitor.sv
`timescale 1ns/1ps
// ------------------------------
// Port checks of the timer read path
// ------------------------------
module timer_readback_monitor #(
    parameter COUNT_WIDTH = 16,
    parameter NUM_COUNTERS = 3
) (
    input wire sys_clk,
    input wire rst_b,
    input wire cs_b,
    input wire rd_b,
    input wire wr_b,
    input wire port_select_high,
    input wire port_select_low,
    input wire [7:0] data_out_q,
    input wire data_oe_b_q,
    input wire [NUM_COUNTERS-1:0] mode_load_q,
    input wire [NUM_COUNTERS*6-1:0] mode_field_q,
    input wire [NUM_COUNTERS-1:0] count_register_load_q
);
    // Counter read as seen at the pins; control location never answers
    wire rd_ok = !rd_b && !cs_b && wr_b && !(port_select_high && port_select_low);
    reg [NUM_COUNTERS*6-1:0] mf_prev_q;
    reg [NUM_COUNTERS-1:0] ml_prev_q;
    reg [NUM_COUNTERS-1:0] mf_chg;
    integer i;
    // Last cycle's fields, so a field may move with its pulse or one edge late
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mf_prev_q <= {NUM_COUNTERS*6{1'b0}};
            ml_prev_q <= {NUM_COUNTERS{1'b0}};
        end else begin
            mf_prev_q <= mode_field_q;
            ml_prev_q <= mode_load_q;
        end
    end
    // Counters whose mode field moved this cycle
    always @* begin
        for (i = 0; i < NUM_COUNTERS; i = i + 1) begin
            mf_chg[i] = mode_field_q[6*i +: 6] != mf_prev_q[6*i +: 6];
        end
    end
    default clocking mon_cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    oe_source_a: assert property ($fell(data_oe_b_q) |-> $past(rd_ok, 2))
        else $error("bus driven without a counter read");
    oe_answer_a: assert property ($fell(rd_b) && rd_ok |-> ##[2:5] !data_oe_b_q)
        else $error("counter read not answered");
    oe_release_a: assert property ($rose(rd_b) |-> ##[2:5] data_oe_b_q)
        else $error("bus not released after read");
    read_hold_a: assert property (!data_oe_b_q && !$past(data_oe_b_q) && $past(rd_ok) && $past(rd_ok, 2)
        |-> $stable(data_out_q))
        else $error("read data moved during a read");
    mode_onehot_a: assert property ($onehot0(mode_load_q))
        else $error("mode pulse on several counters");
    load_onehot_a: assert property ($onehot0(count_register_load_q))
        else $error("count load on several counters");
    mode_cause_a: assert property (|mode_load_q |-> $past(wr_b) && !$past(wr_b, 6)
        && $past(port_select_high, 6) && $past(port_select_low, 6))
        else $error("mode pulse without control write");
    load_cause_a: assert property (|count_register_load_q |-> $past(wr_b) && !$past(wr_b, 6)
        && !($past(port_select_high, 6) && $past(port_select_low, 6)))
        else $error("count load without counter write");
    mode_owner_a: assert property ((mf_chg & ~(mode_load_q | ml_prev_q)) == 0)
        else $error("mode field moved without its mode word");
endmodule // timer_readback_monitor

bind timer_readback timer_readback_monitor #(
    .COUNT_WIDTH(COUNT_WIDTH),
    .NUM_COUNTERS(NUM_COUNTERS)
) mon (.sys_clk, .rst_b, .cs_b, .rd_b, .wr_b, .port_select_high, .port_select_low, .data_out_q,
    .data_oe_b_q, .mode_load_q, .mode_field_q, .count_register_load_q);

// ===== host_port_model.sv
`timescale 1ns/1ps
// ------------------------------
// Host processor on the parallel port
// ------------------------------
module host_port_model (
    input wire sys_clk,
    output reg cs_b,
    output reg rd_b,
    output reg wr_b,
    output reg port_select_high,
    output reg port_select_low,
    output reg [7:0] data_in,
    input wire [7:0] data_out_q,
    input wire data_oe_b_q
);
    // Idle bus at time zero
    initial begin
        {cs_b, rd_b, wr_b} = 3'h7;
        {port_select_high, port_select_low} = 2'h0;
        data_in = 8'h00;
    end
    // Write: strobe low three clocks, since the pins pass two sync flops
    task put(input [1:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            {cs_b, wr_b} <= 2'h0;
            {port_select_high, port_select_low} <= a;
            data_in <= d;
            repeat (3) @(posedge sys_clk);
            wr_b <= 1'b1;
            @(posedge sys_clk);
            cs_b <= 1'b1;
            {port_select_high, port_select_low} <= ~a;
            data_in <= ~d; // Released bus must not keep the last value
            repeat (5) @(posedge sys_clk);
        end
    endtask
    // Read: hold the strobe until the bus is driven, or give up
    task get(input [1:0] a, output [7:0] d, output ok);
        integer k;
        begin
            ok = 1'b0;
            d = 8'h00;
            @(posedge sys_clk);
            {cs_b, rd_b} <= 2'h0;
            {port_select_high, port_select_low} <= a;
            for (k = 0; k < 12 && !ok; k = k + 1) begin
                @(posedge sys_clk);
                ok = data_oe_b_q === 1'b0;
                d = ok ? data_out_q : ~data_out_q; // Floated bus reads as inverse
            end
            {cs_b, rd_b} <= 2'h3;
            {port_select_high, port_select_low} <= ~a;
            repeat (6) @(posedge sys_clk);
        end
    endtask
endmodule // host_port_model

// ===== interval_timer_count_readback_bench.sv
`timescale 1ns/1ps
module interval_timer_count_readback_bench;
    reg sys_clk = 1'b0;
    reg rst_b = 1'b0;
    reg run = 1'b0;
    reg [47:0] count_element = 48'h0000_0000_0000;
    reg [2:0] out_level = 3'h0;
    reg [2:0] count_loaded = 3'h0;
    wire cs_b, rd_b, wr_b, port_select_high, port_select_low, data_oe_b_q;
    wire [7:0] data_in, data_out_q;
    wire [2:0] mode_load_q, count_register_load_q;
    wire [17:0] mode_field_q;
    wire [47:0] count_register_q;
    integer n_fail = 0;
    integer compares = 0;
    integer seed = 32'h70cc_d1c1;
    integer i, j;
    reg [5:0] mode [0:2];
    reg [15:0] snap [0:2];
    reg [15:0] cnt;
    reg [7:0] b0, b1;
    reg [2:0] np, o_snap;
    reg ok;
    // ------------------------------
    // Clock, device, host
    // ------------------------------
    always #25 sys_clk = ~sys_clk;
    timer_readback dut (.sys_clk, .rst_b, .cs_b, .rd_b, .wr_b, .port_select_high, .port_select_low,
        .data_in, .data_out_q, .data_oe_b_q, .count_element, .out_level, .count_loaded, .mode_load_q,
        .mode_field_q, .count_register_load_q, .count_register_q);
    host_port_model host (.sys_clk, .cs_b, .rd_b, .wr_b, .port_select_high, .port_select_low,
        .data_in, .data_out_q, .data_oe_b_q);
    // Counter core stand-in: counts at random while running, else still
    always @(posedge sys_clk) begin
        if (run) begin
            count_element <= 48'({$random(seed), $random(seed)});
            out_level <= 3'($random(seed));
        end
    end
    // ------------------------------
    // Helpers
    // ------------------------------
    task check_val(input string what, input [15:0] exp, input [15:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    function [7:0] rb_cmd(input cnt_b, input st_b, input [2:0] sel);
        rb_cmd = {2'h3, cnt_b, st_b, sel, 1'b0};
    endfunction
    function [7:0] stat(input integer n);
        stat = {o_snap[n], np[n], mode[n]};
    endfunction
    // Stopping takes two edges: the edge that clears run still counts once
    task freeze;
        begin
            @(posedge sys_clk);
            run <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task go;
        begin
            @(posedge sys_clk);
            run <= 1'b1;
            repeat (4) @(posedge sys_clk);
        end
    endtask
    // Kind 0 single latches, 1 count read-back, 2 count and status read-back
    task issue(input integer kind);
        integer k;
        begin
            if (kind == 0) begin
                for (k = 0; k < 3; k = k + 1) host.put(2'h3, {k[1:0], 6'h00});
            end else begin
                host.put(2'h3, rb_cmd(1'b0, kind != 2, 3'h7));
            end
        end
    endtask
    task read_count(input [1:0] n, input [15:0] exp);
        begin
            host.get(n, b0, ok);
            host.get(n, b1, ok);
            check_val("count", exp, {b1, b0});
        end
    endtask
    task test_done;
        begin
            if (n_fail == 0 && compares > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    // ------------------------------
    // Tests
    // ------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // Two-byte format on every counter, random mode and count
        for (i = 0; i < 3; i = i + 1) begin
            mode[i] = {2'h3, 4'($random(seed))};
            cnt = 16'($random(seed));
            host.put(2'h3, {i[1:0], mode[i]});
            check_val("mode field", mode[i], mode_field_q[6*i +: 6]);
            host.put(i[1:0], cnt[7:0]);
            host.put(i[1:0], cnt[15:8]);
            check_val("count register", cnt, count_register_q[16*i +: 16]);
        end
        // Only counter zero has taken its count
        np = 3'h6;
        @(posedge sys_clk);
        count_loaded <= 3'h1;
        @(posedge sys_clk);
        count_loaded <= 3'h0;
        // Latch, let the count move, latch again, read latched then live
        for (j = 0; j < 3; j = j + 1) begin
            freeze;
            for (i = 0; i < 3; i = i + 1) snap[i] = count_element[16*i +: 16];
            o_snap = out_level;
            issue(j);
            go;
            freeze;
            issue(j);
            go;
            for (i = 0; i < 3; i = i + 1) begin
                if (j == 2) begin
                    host.get(i[1:0], b0, ok);
                    check_val("status", stat(i), b0);
                end
                read_count(i[1:0], snap[i]);
            end
            freeze;
            for (i = 0; i < 3; i = i + 1) read_count(i[1:0], count_element[16*i +: 16]);
        end
        // Reads and writes of one counter interleaved
        snap[1] = count_element[31:16];
        host.put(2'h3, 8'h40);
        host.get(2'h1, b0, ok);
        cnt = 16'($random(seed));
        host.put(2'h1, cnt[7:0]);
        host.get(2'h1, b1, ok);
        host.put(2'h1, cnt[15:8]);
        check_val("interleaved read", snap[1], {b1, b0});
        check_val("interleaved write", cnt, count_register_q[31:16]);
        // Mode word drops pending latches; empty read-back latches nothing
        host.put(2'h3, rb_cmd(1'b0, 1'b0, 3'h4));
        host.put(2'h3, {2'h2, mode[2]});
        host.put(2'h3, rb_cmd(1'b0, 1'b0, 3'h0));
        go;
        freeze;
        read_count(2'h2, count_element[47:32]);
        // Status alone, after another counter's mode word
        o_snap = out_level;
        host.put(2'h3, rb_cmd(1'b1, 1'b0, 3'h1));
        host.get(2'h0, b0, ok);
        check_val("status only", stat(0), b0);
        read_count(2'h0, count_element[15:0]);
        host.get(2'h3, b0, ok);
        check_val("control read", 16'h0000, ok);
        test_done;
    end
    // Whole run is well under a millisecond
    initial begin
        #1000000;
        n_fail = n_fail + 1;
        test_done;
    end
endmodule // interval_timer_count_readback_bench
